// *** common/ibcl_pkg.sv ***
// Shared constants, encodings and carriers for the inter-bank command host
package ibcl_pkg;
    // Clock and bank geometry
    localparam int MCLK_NS = 40;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int ADDR_W = 14;
    localparam int DQ_W = 16;
    localparam int BURST_LEN = 4;
    localparam int BEAT_W = 2;

    // Times in their own units, figures are plain defaults
    localparam int ACT_TO_ACT_DELAY_NS = 10;
    localparam int ROW_TO_COLUMN_DELAY_NS = 18;
    localparam int PRECHARGE_TIME_NS = 18;
    localparam int POWER_DOWN_EXIT_TIME_NS = 8;
    localparam int SELF_REFRESH_EXIT_TIME_NS = 140;
    localparam int REFRESH_ALL_NS = 130;
    localparam int INIT_TIME_NS = 4000;
    localparam int MODE_READ_TIME_CK = 2;
    localparam int MODE_WRITE_TIME_CK = 5;
    localparam int MCLK_PER_CK = 2;

    // Least times rounded up to whole mclk cycles
    localparam logic [7:0] RRD_CYC =
        8'((ACT_TO_ACT_DELAY_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [7:0] RCD_CYC =
        8'((ROW_TO_COLUMN_DELAY_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [7:0] RP_CYC =
        8'((PRECHARGE_TIME_NS + MCLK_NS - 1) / MCLK_NS);
    localparam int EXIT_NS =
        (POWER_DOWN_EXIT_TIME_NS > SELF_REFRESH_EXIT_TIME_NS) ?
        POWER_DOWN_EXIT_TIME_NS : SELF_REFRESH_EXIT_TIME_NS;
    localparam logic [7:0] EXIT_CYC = 8'((EXIT_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [7:0] REF_CYC =
        8'((REFRESH_ALL_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [7:0] INIT_CYC =
        8'((INIT_TIME_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [7:0] MRR_CYC = 8'(MODE_READ_TIME_CK * MCLK_PER_CK);
    localparam logic [7:0] MRW_CYC = 8'(MODE_WRITE_TIME_CK * MCLK_PER_CK);
    localparam logic [7:0] BURST_CYC = 8'(BURST_LEN);

    // Mode register address that starts device auto-initialization
    localparam logic [ADDR_W-1:0] MRW_RESET_ADDR = 14'h003f;

    typedef enum logic [3:0] {
        IBCL_NOP, IBCL_ACT, IBCL_RD, IBCL_WR, IBCL_PRE,
        IBCL_MODE_REG_READ_CMD, IBCL_MODE_REG_WRITE_CMD, IBCL_REF,
        IBCL_BURST_TERMINATE_CMD
    } ibcl_cmd_t;

    typedef enum logic [2:0] {
        BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READING, BK_WRITING,
        BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
    } ibcl_bank_st_t;

    typedef enum logic [1:0] {
        DEV_POWER_ON, DEV_RESETTING, DEV_READY
    } ibcl_dev_st_t;

    typedef struct packed {
        ibcl_cmd_t cmd;
        logic [BANK_W-1:0] bank;
        logic all_banks;
        logic auto_pre;
        logic [ADDR_W-1:0] addr;
        logic [BURST_LEN*DQ_W-1:0] wdata;
        logic [BURST_LEN-1:0] write_data_mask;
    } ibcl_req_t;

    typedef struct packed {
        logic cke;
        logic cs_n;
        ibcl_cmd_t cmd;
        logic [BANK_W-1:0] bank;
        logic all_banks;
        logic auto_pre;
        logic [ADDR_W-1:0] addr;
    } ibcl_pins_t;

    typedef struct packed {
        ibcl_dev_st_t dev;
        logic [7:0] dev_cnt;
        logic [7:0] mr_cnt;
        logic [7:0] ref_cnt;
        logic [7:0] rrd_cnt;
        logic [7:0] exit_cnt;
        logic [7:0] burst_cnt;
        logic [BANK_W-1:0] burst_bank;
        logic burst_wr;
        logic cke;
        logic cke_prev;
    } ibcl_ctl_t;
endpackage : ibcl_pkg

// *** logic/ibcl_bank_track.sv ***
// Per-bank state tracker with activate and precharge timers
`timescale 1ns/1ps
module ibcl_bank_track (
    input wire logic mclk,
    input wire logic srst,
    input wire logic issue,
    input wire ibcl_pkg::ibcl_cmd_t cmd,
    input wire logic auto_pre,
    input wire logic burst_end,
    output ibcl_pkg::ibcl_bank_st_t state
);
    typedef struct packed {
        ibcl_pkg::ibcl_bank_st_t st;
        logic [7:0] cnt;
    } ibcl_bk_t;

    ibcl_bk_t q;
    ibcl_bk_t d;

    // Next state; a new command outranks a burst ending that cycle
    always_comb begin
        d = q;
        if (q.cnt != 8'h00) begin
            d.cnt = q.cnt - 8'h01;
        end
        unique case (q.st)
            ibcl_pkg::BK_IDLE: begin
                if (issue && cmd == ibcl_pkg::IBCL_ACT) begin
                    d.st = ibcl_pkg::BK_ACTIVATING;
                    d.cnt = ibcl_pkg::RCD_CYC;
                end else if (issue && cmd == ibcl_pkg::IBCL_PRE) begin
                    d.st = ibcl_pkg::BK_PRECHARGING; // Still pays precharge_time
                    d.cnt = ibcl_pkg::RP_CYC;
                end
            end
            ibcl_pkg::BK_ACTIVATING: begin
                if (q.cnt == 8'h00) begin
                    d.st = ibcl_pkg::BK_ACTIVE;
                end
            end
            ibcl_pkg::BK_PRECHARGING: begin
                if (q.cnt == 8'h00) begin
                    d.st = ibcl_pkg::BK_IDLE;
                end
            end
            ibcl_pkg::BK_READ_AP, ibcl_pkg::BK_WRITE_AP: begin
                if (burst_end) begin
                    d.st = ibcl_pkg::BK_PRECHARGING;
                    d.cnt = ibcl_pkg::RP_CYC;
                end
            end
            default: begin
                // Active, reading and writing share the column commands
                if (issue && cmd == ibcl_pkg::IBCL_RD) begin
                    d.st = auto_pre ? ibcl_pkg::BK_READ_AP :
                        ibcl_pkg::BK_READING;
                end else if (issue && cmd == ibcl_pkg::IBCL_WR) begin
                    d.st = auto_pre ? ibcl_pkg::BK_WRITE_AP :
                        ibcl_pkg::BK_WRITING;
                end else if (issue && cmd == ibcl_pkg::IBCL_PRE) begin
                    d.st = ibcl_pkg::BK_PRECHARGING;
                    d.cnt = ibcl_pkg::RP_CYC;
                end else if (burst_end) begin
                    d.st = ibcl_pkg::BK_ACTIVE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= '{st: ibcl_pkg::BK_IDLE, cnt: 8'h00};
        end else begin
            q <= d;
        end
    end

    assign state = q.st;
endmodule : ibcl_bank_track

// *** logic/ibcl_link_drv.sv ***
// Link clock divider, command pin register and write data shifter
`timescale 1ns/1ps
module ibcl_link_drv (
    input wire logic mclk,
    input wire logic srst,
    input wire logic issue,
    input wire ibcl_pkg::ibcl_pins_t pins_in,
    input wire logic cke,
    input wire logic wr_start,
    input wire logic [ibcl_pkg::BURST_LEN*ibcl_pkg::DQ_W-1:0] wdata,
    input wire logic [ibcl_pkg::BURST_LEN-1:0] wmask,
    output logic slot,
    output logic ck_o,
    output ibcl_pkg::ibcl_pins_t pins,
    output logic [ibcl_pkg::DQ_W-1:0] dq_o,
    output logic dq_oe,
    output logic dm_o
);
    typedef struct packed {
        logic ck;
        ibcl_pkg::ibcl_pins_t pins;
        logic [ibcl_pkg::BURST_LEN*ibcl_pkg::DQ_W-1:0] buf_data;
        logic [ibcl_pkg::BURST_LEN-1:0] buf_mask;
        logic [ibcl_pkg::BEAT_W:0] beats_left;
        logic [ibcl_pkg::BEAT_W-1:0] beat;
        logic [ibcl_pkg::DQ_W-1:0] dq;
        logic oe;
        logic dm;
    } ibcl_lnk_t;

    ibcl_lnk_t q;
    ibcl_lnk_t d;

    // Pins other than cke change as ck falls so the device samples mid-period at ck rise; cke changes every mclk
    always_comb begin
        d = q;
        d.ck = ~q.ck;
        d.pins.cke = cke;
        if (q.ck) begin
            if (issue) begin
                d.pins = pins_in;
                d.pins.cke = cke;
            end else begin
                d.pins.cs_n = 1'b1;
                d.pins.cmd = ibcl_pkg::IBCL_NOP;
            end
        end
        // One beat per mclk; mask high inhibits that beat
        d.oe = 1'b0;
        d.dm = 1'b0;
        if (q.beats_left != '0) begin
            d.dq = q.buf_data[q.beat*ibcl_pkg::DQ_W +: ibcl_pkg::DQ_W];
            d.dm = q.buf_mask[q.beat];
            d.oe = 1'b1;
            d.beat = q.beat + 2'h1;
            d.beats_left = q.beats_left - 3'h1;
        end
        if (wr_start) begin
            d.buf_data = wdata;
            d.buf_mask = wmask;
            d.beat = '0;
            d.beats_left = 3'(ibcl_pkg::BURST_LEN);
        end
    end

    // Link register
    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= '0;
            q.pins.cs_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign slot = q.ck;
    assign ck_o = q.ck;
    assign pins = q.pins;
    assign dq_o = q.dq;
    assign dq_oe = q.oe;
    assign dm_o = q.dm;
endmodule : ibcl_link_drv

// *** logic/ibcl_host_ctrl.sv ***
// Host that issues only legal inter-bank commands to the memory
`timescale 1ns/1ps
module ibcl_host_ctrl (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cke_req,
    input wire logic req_valid,
    input wire ibcl_pkg::ibcl_req_t req,
    output logic req_ready,
    output logic req_refused,
    output logic busy,
    output ibcl_pkg::ibcl_dev_st_t dev_state,
    output logic ck_o,
    output ibcl_pkg::ibcl_pins_t pins,
    output logic [ibcl_pkg::DQ_W-1:0] dq_o,
    output logic dq_oe,
    output logic dm_o
);
    localparam int NB = ibcl_pkg::NUM_BANKS;

    ibcl_pkg::ibcl_ctl_t q;
    ibcl_pkg::ibcl_ctl_t d;
    ibcl_pkg::ibcl_bank_st_t [NB-1:0] bank_st;
    logic [NB-1:0] bank_issue;
    logic [NB-1:0] bank_burst_end;
    logic slot;
    logic legal;
    logic take;
    logic issue;
    logic timing_ok;
    logic burst_on;
    logic burst_fin;
    logic is_reset;
    ibcl_pkg::ibcl_pins_t cmd_pins;

    // Bank may take a precharge, alone or as part of precharge-all
    function automatic logic pre_ok(input ibcl_pkg::ibcl_bank_st_t s);
        pre_ok = s == ibcl_pkg::BK_IDLE || s == ibcl_pkg::BK_ACTIVE ||
            s == ibcl_pkg::BK_READING || s == ibcl_pkg::BK_WRITING;
    endfunction : pre_ok

    // Bank may sit beside a mode register read
    function automatic logic mrr_ok(input ibcl_pkg::ibcl_bank_st_t s);
        mrr_ok = s == ibcl_pkg::BK_IDLE || s == ibcl_pkg::BK_ACTIVE ||
            s == ibcl_pkg::BK_ACTIVATING ||
            s == ibcl_pkg::BK_PRECHARGING;
    endfunction : mrr_ok

    // Legality of one request against the target and every other bank
    function automatic logic cmd_legal(
        input ibcl_pkg::ibcl_req_t r,
        input ibcl_pkg::ibcl_bank_st_t [NB-1:0] s,
        input ibcl_pkg::ibcl_dev_st_t dev,
        input logic bon,
        input logic [ibcl_pkg::BANK_W-1:0] bbank,
        input logic bwr
    );
        logic all_idle;
        logic all_pre;
        logic all_mrr;
        logic ok;
        ibcl_pkg::ibcl_bank_st_t t;
        all_idle = 1'b1;
        all_pre = 1'b1;
        all_mrr = 1'b1;
        t = s[r.bank];
        for (int i = 0; i < NB; i++) begin
            all_idle = all_idle & (s[i] == ibcl_pkg::BK_IDLE);
            all_pre = all_pre & pre_ok(s[i]);
            all_mrr = all_mrr & mrr_ok(s[i]);
        end
        ok = 1'b0;
        if (r.cmd == ibcl_pkg::IBCL_NOP) begin
            ok = 1'b1;
        end else if (dev == ibcl_pkg::DEV_POWER_ON) begin
            // Only the reset mode write leaves power-on
            ok = r.cmd == ibcl_pkg::IBCL_MODE_REG_WRITE_CMD &&
                r.addr == ibcl_pkg::MRW_RESET_ADDR;
        end else if (dev == ibcl_pkg::DEV_RESETTING) begin
            ok = r.cmd == ibcl_pkg::IBCL_MODE_REG_READ_CMD;
        end else begin
            unique case (r.cmd)
                ibcl_pkg::IBCL_ACT: begin
                    ok = t == ibcl_pkg::BK_IDLE;
                end
                // Flag auto_pre is not looked at here
                ibcl_pkg::IBCL_RD: begin
                    ok = (t == ibcl_pkg::BK_ACTIVE ||
                        t == ibcl_pkg::BK_READING ||
                        t == ibcl_pkg::BK_WRITING) &&
                        !(bon && bwr);
                end
                ibcl_pkg::IBCL_WR: begin
                    ok = (t == ibcl_pkg::BK_ACTIVE ||
                        t == ibcl_pkg::BK_READING ||
                        t == ibcl_pkg::BK_WRITING) &&
                        !(bon && !bwr);
                end
                ibcl_pkg::IBCL_PRE: begin
                    ok = r.all_banks ? all_pre : pre_ok(t);
                end
                ibcl_pkg::IBCL_MODE_REG_READ_CMD: begin
                    ok = all_mrr && !bon;
                end
                ibcl_pkg::IBCL_MODE_REG_WRITE_CMD, ibcl_pkg::IBCL_REF: begin
                    ok = all_idle && !bon;
                end
                ibcl_pkg::IBCL_BURST_TERMINATE_CMD: begin
                    ok = bon && r.bank == bbank;
                end
                default: begin
                    ok = 1'b0;
                end
            endcase
        end
        cmd_legal = ok;
    endfunction : cmd_legal

    assign burst_on = q.burst_cnt != 8'h00;
    assign burst_fin = q.burst_cnt == 8'h01;
    assign is_reset = req.cmd == ibcl_pkg::IBCL_MODE_REG_WRITE_CMD &&
        req.addr == ibcl_pkg::MRW_RESET_ADDR;

    // Temporary holds stall the request rather than refuse it
    assign timing_ok = q.cke && q.cke_prev && q.exit_cnt == 8'h00 &&
        q.mr_cnt == 8'h00 &&
        q.ref_cnt == 8'h00 &&
        !(req.cmd == ibcl_pkg::IBCL_ACT && q.rrd_cnt != 8'h00);

    assign legal = cmd_legal(req, bank_st, q.dev, burst_on, q.burst_bank,
        q.burst_wr);
    assign req_ready = slot && timing_ok;
    assign take = req_valid && req_ready;
    assign issue = take && legal && req.cmd != ibcl_pkg::IBCL_NOP;
    assign req_refused = take && !legal;
    assign busy = !timing_ok || burst_on;
    assign dev_state = q.dev;

    // Banks hit by this command; precharge-all reaches every bank
    always_comb begin
        for (int i = 0; i < NB; i++) begin
            bank_issue[i] = issue && (req.bank == ibcl_pkg::BANK_W'(i) ||
                (req.cmd == ibcl_pkg::IBCL_PRE && req.all_banks));
            bank_burst_end[i] = q.burst_bank == ibcl_pkg::BANK_W'(i) &&
                (burst_fin || (issue &&
                req.cmd == ibcl_pkg::IBCL_BURST_TERMINATE_CMD));
        end
    end

    // Control state: timers, burst owner, device phase, clock enable
    always_comb begin
        d = q;
        d.cke = cke_req;
        d.cke_prev = q.cke;
        if (q.dev_cnt != 8'h00) d.dev_cnt = q.dev_cnt - 8'h01;
        if (q.mr_cnt != 8'h00) d.mr_cnt = q.mr_cnt - 8'h01;
        if (q.ref_cnt != 8'h00) d.ref_cnt = q.ref_cnt - 8'h01;
        if (q.rrd_cnt != 8'h00) d.rrd_cnt = q.rrd_cnt - 8'h01;
        if (q.exit_cnt != 8'h00) d.exit_cnt = q.exit_cnt - 8'h01;
        if (q.burst_cnt != 8'h00) d.burst_cnt = q.burst_cnt - 8'h01;
        // Exit timer on any rise of clock enable
        if (cke_req && !q.cke) begin
            d.exit_cnt = ibcl_pkg::EXIT_CYC;
        end
        // Resetting ends after the init time, mode reads do not pause it
        if (q.dev == ibcl_pkg::DEV_RESETTING && q.dev_cnt == 8'h00) begin
            d.dev = ibcl_pkg::DEV_READY;
        end
        if (issue) begin
            unique case (req.cmd)
                ibcl_pkg::IBCL_ACT: d.rrd_cnt = ibcl_pkg::RRD_CYC;
                ibcl_pkg::IBCL_RD, ibcl_pkg::IBCL_WR: begin
                    d.burst_cnt = ibcl_pkg::BURST_CYC;
                    d.burst_bank = req.bank;
                    d.burst_wr = req.cmd == ibcl_pkg::IBCL_WR;
                end
                ibcl_pkg::IBCL_BURST_TERMINATE_CMD: begin
                    d.burst_cnt = 8'h00;
                end
                ibcl_pkg::IBCL_MODE_REG_READ_CMD: begin
                    d.mr_cnt = ibcl_pkg::MRR_CYC;
                end
                ibcl_pkg::IBCL_MODE_REG_WRITE_CMD: begin
                    d.mr_cnt = ibcl_pkg::MRW_CYC;
                    if (is_reset) begin
                        d.dev = ibcl_pkg::DEV_RESETTING;
                        d.dev_cnt = ibcl_pkg::INIT_CYC;
                    end
                end
                ibcl_pkg::IBCL_REF: d.ref_cnt = ibcl_pkg::REF_CYC;
                default: begin
                end
            endcase
        end
    end

    // Control register; starts in power-on with clock enable low
    always_ff @(posedge mclk) begin
        if (srst) begin
            q <= '0;
            q.dev <= ibcl_pkg::DEV_POWER_ON;
        end else begin
            q <= d;
        end
    end

    // Command fields towards the pins; chip select low for real commands
    always_comb begin
        cmd_pins = '0;
        cmd_pins.cs_n = 1'b0;
        cmd_pins.cmd = req.cmd;
        cmd_pins.bank = req.bank;
        cmd_pins.all_banks = req.all_banks;
        cmd_pins.auto_pre = req.auto_pre;
        cmd_pins.addr = req.addr;
    end

    // One tracker per bank keeps each state apart
    for (genvar g = 0; g < NB; g++) begin : g_bank
        ibcl_bank_track u_bank (
            .mclk(mclk),
            .srst(srst),
            .issue(bank_issue[g]),
            .cmd(req.cmd),
            .auto_pre(req.auto_pre),
            .burst_end(bank_burst_end[g]),
            .state(bank_st[g])
        );
    end

    // Link side; ck is mclk halved, so it is no separate domain
    ibcl_link_drv u_link (
        .mclk(mclk),
        .srst(srst),
        .issue(issue),
        .pins_in(cmd_pins),
        .cke(q.cke),
        .wr_start(issue && req.cmd == ibcl_pkg::IBCL_WR),
        .wdata(req.wdata),
        .wmask(req.write_data_mask),
        .slot(slot),
        .ck_o(ck_o),
        .pins(pins),
        .dq_o(dq_o),
        .dq_oe(dq_oe),
        .dm_o(dm_o)
    );
endmodule : ibcl_host_ctrl

// *** tb/ibcl_host_monitor.sv ***
// Port checker for the inter-bank command host
`timescale 1ns/1ps
module ibcl_host_monitor (
    input wire logic mclk,
    input wire logic srst,
    input wire logic cke_req,
    input wire logic req_valid,
    input wire ibcl_pkg::ibcl_req_t req,
    input wire logic req_ready,
    input wire logic req_refused,
    input wire logic busy,
    input wire ibcl_pkg::ibcl_dev_st_t dev_state,
    input wire logic ck_o,
    input wire ibcl_pkg::ibcl_pins_t pins,
    input wire logic [ibcl_pkg::DQ_W-1:0] dq_o,
    input wire logic dq_oe,
    input wire logic dm_o
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    // Offered and accepted requests
    wire logic offer = req_valid && req_ready;
    wire logic take = offer && !req_refused;

    property p_rst_quiet;
        $fell(srst) |-> pins.cs_n && !dq_oe;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("pins active after reset");
    property p_cke_gate;
        !pins.cs_n |-> pins.cke && $past(pins.cke);
    endproperty
    a_cke_gate: assert property (p_cke_gate)
        else $error("cke not twice high");
    property p_take_pins;
        take && req.cmd inside {ibcl_pkg::IBCL_ACT, ibcl_pkg::IBCL_RD,
            ibcl_pkg::IBCL_WR} |=> !pins.cs_n &&
            pins.cmd == $past(req.cmd) && pins.bank == $past(req.bank);
    endproperty
    a_take_pins: assert property (p_take_pins)
        else $error("command not on pins");
    property p_refused_nop;
        req_refused |=> pins.cs_n;
    endproperty
    a_refused_nop: assert property (p_refused_nop)
        else $error("refused reached pins");
    property p_mrr_quiet;
        $fell(pins.cs_n) && pins.cmd == ibcl_pkg::IBCL_MODE_REG_READ_CMD
            |=> ##1 pins.cs_n [*2];
    endproperty
    a_mrr_quiet: assert property (p_mrr_quiet)
        else $error("cmd in mode read time");
    property p_mrw_quiet;
        $fell(pins.cs_n) && pins.cmd == ibcl_pkg::IBCL_MODE_REG_WRITE_CMD
            |=> ##1 pins.cs_n [*8];
    endproperty
    a_mrw_quiet: assert property (p_mrw_quiet)
        else $error("cmd in mode write time");
    property p_wr_beats;
        $fell(pins.cs_n) && pins.cmd == ibcl_pkg::IBCL_WR |=> dq_oe [*4];
    endproperty
    a_wr_beats: assert property (p_wr_beats)
        else $error("write beats not driven");
    property p_bst_idle;
        offer && !busy && req.cmd == ibcl_pkg::IBCL_BURST_TERMINATE_CMD
            |-> req_refused;
    endproperty
    a_bst_idle: assert property (p_bst_idle)
        else $error("terminate with no burst");
    property p_power_on;
        offer && dev_state == ibcl_pkg::DEV_POWER_ON && req.cmd inside
            {ibcl_pkg::IBCL_ACT, ibcl_pkg::IBCL_RD, ibcl_pkg::IBCL_WR,
            ibcl_pkg::IBCL_PRE, ibcl_pkg::IBCL_REF} |-> req_refused;
    endproperty
    a_power_on: assert property (p_power_on)
        else $error("bank cmd at power on");
    property p_reset_enter;
        take && dev_state == ibcl_pkg::DEV_POWER_ON &&
            req.cmd == ibcl_pkg::IBCL_MODE_REG_WRITE_CMD &&
            req.addr == ibcl_pkg::MRW_RESET_ADDR
            |-> ##[1:2] dev_state == ibcl_pkg::DEV_RESETTING;
    endproperty
    a_reset_enter: assert property (p_reset_enter)
        else $error("reset write did not start init");

    // Main scenarios reached
    c_write: cover property (take && req.cmd == ibcl_pkg::IBCL_WR);
    c_refused: cover property (req_refused);
    c_cke: cover property ($rose(cke_req));
endmodule : ibcl_host_monitor

bind ibcl_host_ctrl ibcl_host_monitor mon_u (.*);

// *** tb/ibcl_mem_model.sv ***
// Behavioural memory device on the far side of the command pins
`timescale 1ns/1ps
module ibcl_mem_model (
    input wire logic mclk,
    input wire logic ck_o,
    input wire ibcl_pkg::ibcl_pins_t pins,
    input wire logic [ibcl_pkg::DQ_W-1:0] dq_o,
    input wire logic dq_oe,
    input wire logic dm_o,
    output logic [7:0] viol_cnt,
    output logic [7:0] wr_cnt,
    output logic [ibcl_pkg::DQ_W-1:0] last_word
);
    logic [ibcl_pkg::NUM_BANKS-1:0] open_q = '0;
    initial viol_cnt = 8'h00;
    initial wr_cnt = 8'h00;

    // Commands taken at ck rise
    always @(posedge ck_o) begin
        if (!pins.cs_n) begin
            case (pins.cmd)
                ibcl_pkg::IBCL_ACT: begin
                    if (open_q[pins.bank]) viol_cnt <= viol_cnt + 8'h01;
                    open_q[pins.bank] <= 1'b1;
                end
                ibcl_pkg::IBCL_RD, ibcl_pkg::IBCL_WR: begin
                    if (!open_q[pins.bank]) viol_cnt <= viol_cnt + 8'h01;
                    if (pins.auto_pre) open_q[pins.bank] <= 1'b0;
                end
                ibcl_pkg::IBCL_PRE: begin
                    if (pins.all_banks) open_q <= '0;
                    else open_q[pins.bank] <= 1'b0;
                end
                ibcl_pkg::IBCL_REF, ibcl_pkg::IBCL_MODE_REG_WRITE_CMD: begin
                    if (open_q != '0) viol_cnt <= viol_cnt + 8'h01;
                end
                // Bank states unchanged
                default: ;
            endcase
        end
    end

    // Unmasked beats stored
    always @(posedge mclk) begin
        if (dq_oe && !dm_o) begin
            wr_cnt <= wr_cnt + 8'h01;
            last_word <= dq_o;
        end
    end
endmodule : ibcl_mem_model

// *** tb/ibcl_host_ctrl_tb.sv ***
// Self-checking bench for the inter-bank command host
`timescale 1ns/1ps
module ibcl_host_ctrl_tb;
    logic mclk, srst, cke_req, req_valid;
    logic req_ready, req_refused, busy, ck_o, dq_oe, dm_o;
    ibcl_pkg::ibcl_req_t req;
    ibcl_pkg::ibcl_dev_st_t dev_state;
    ibcl_pkg::ibcl_pins_t pins;
    logic [ibcl_pkg::DQ_W-1:0] dq_o, last_word;
    logic [7:0] viol_cnt, wr_cnt;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    ibcl_host_ctrl dut_u (.mclk, .srst, .cke_req, .req_valid, .req,
        .req_ready, .req_refused, .busy, .dev_state, .ck_o, .pins, .dq_o,
        .dq_oe, .dm_o);
    ibcl_mem_model mem_u (.mclk, .ck_o, .pins, .dq_o, .dq_oe, .dm_o,
        .viol_cnt, .wr_cnt, .last_word);

    // 25 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : chk

    // Request held until taken
    task automatic send(input ibcl_pkg::ibcl_cmd_t c, input logic [2:0] b,
                        input logic [1:0] f, input logic [13:0] a,
                        input logic rf);
        int n;
        logic got;
        n = 0;
        @(posedge mclk);
        #1;
        req.cmd = c;
        req.bank = b;
        {req.all_banks, req.auto_pre} = f;
        req.addr = a;
        req_valid = 1'b1;
        do begin
            @(negedge mclk);
            n++;
        end while (req_ready !== 1'b1 && n < 300);
        got = req_refused;
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        chk(got, rf, "refusal");
        if (!rf) chk(pins.cmd, c, "command on pins");
    endtask : send

    // Beat 0 one edge after the take
    task automatic beats(input logic [63:0] d, input logic [3:0] m);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            #1;
            chk(dq_oe, 1'b1, "beat driven");
            chk(dq_o, d[16*i +: 16], "beat data");
            chk(dm_o, m[i], "beat mask");
        end
    endtask : beats

    // Reset write, then init to ready
    task automatic t_init;
        int n;
        n = 0;
        send(ibcl_pkg::IBCL_ACT, 3'h0, 2'h0, 14'h0, 1'b1);
        send(ibcl_pkg::IBCL_MODE_REG_WRITE_CMD, 3'h0, 2'h0,
             ibcl_pkg::MRW_RESET_ADDR, 1'b0);
        chk(dev_state, ibcl_pkg::DEV_RESETTING, "resetting");
        while (dev_state !== ibcl_pkg::DEV_READY && n < 300) begin
            @(posedge mclk);
            n++;
        end
        #1;
        chk(dev_state, ibcl_pkg::DEV_READY, "ready");
        $display("test init done");
    endtask : t_init

    // Bursts, masks, terminates
    task automatic t_burst;
        send(ibcl_pkg::IBCL_ACT, 3'h0, 2'h0, 14'h0, 1'b0);
        send(ibcl_pkg::IBCL_ACT, 3'h1, 2'h0, 14'h0, 1'b0);
        req.wdata = 64'h4444_3333_2222_1111;
        req.write_data_mask = 4'h5;
        send(ibcl_pkg::IBCL_WR, 3'h0, 2'h0, 14'h0, 1'b0);
        fork
            beats(64'h4444_3333_2222_1111, 4'h5);
            send(ibcl_pkg::IBCL_RD, 3'h1, 2'h0, 14'h0, 1'b1);
        join
        req.write_data_mask = 4'hf;
        send(ibcl_pkg::IBCL_WR, 3'h1, 2'h0, 14'h0, 1'b0);
        fork
            beats(64'h4444_3333_2222_1111, 4'hf);
            send(ibcl_pkg::IBCL_BURST_TERMINATE_CMD, 3'h0, 2'h0, 14'h0,
                 1'b1);
        join
        send(ibcl_pkg::IBCL_BURST_TERMINATE_CMD, 3'h1, 2'h0, 14'h0,
             1'b1);
        send(ibcl_pkg::IBCL_RD, 3'h1, 2'h0, 14'h0, 1'b0);
        chk(wr_cnt, 8'h02, "beats stored");
        chk(last_word, 16'h4444, "last stored beat");
        $display("test bursts done");
    endtask : t_burst

    // Device-wide commands, precharge all
    task automatic t_wide;
        send(ibcl_pkg::IBCL_REF, 3'h0, 2'h0, 14'h0, 1'b1);
        send(ibcl_pkg::IBCL_MODE_REG_WRITE_CMD, 3'h0, 2'h0,
             ibcl_pkg::MRW_RESET_ADDR, 1'b1);
        send(ibcl_pkg::IBCL_MODE_REG_READ_CMD, 3'h0, 2'h0, 14'h0,
             1'b0);
        send(ibcl_pkg::IBCL_PRE, 3'h0, 2'h2, 14'h0, 1'b0);
        repeat (ibcl_pkg::RP_CYC + 2) @(posedge mclk);
        send(ibcl_pkg::IBCL_REF, 3'h0, 2'h0, 14'h0, 1'b0);
        $display("test bank wide done");
    endtask : t_wide

    // Auto precharge locks its own bank only
    task automatic t_autopre;
        send(ibcl_pkg::IBCL_ACT, 3'h2, 2'h0, 14'h0, 1'b0);
        repeat (ibcl_pkg::RCD_CYC + 2) @(posedge mclk);
        send(ibcl_pkg::IBCL_RD, 3'h2, 2'h1, 14'h0, 1'b0);
        send(ibcl_pkg::IBCL_RD, 3'h2, 2'h0, 14'h0, 1'b1);
        send(ibcl_pkg::IBCL_ACT, 3'h3, 2'h0, 14'h0, 1'b0);
        $display("test auto precharge done");
    endtask : t_autopre

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    // Reset ten cycles, then scenarios
    initial begin
        srst = 1'b1;
        cke_req = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (10) @(posedge mclk);
        #1;
        srst = 1'b0;
        cke_req = 1'b1;
        t_init();
        t_burst();
        t_wide();
        t_autopre();
        chk(viol_cnt, 8'h00, "device saw illegal command");
        complete_run();
    end
endmodule : ibcl_host_ctrl_tb
